/* verilog/sgp_port.sv */
// Six-bit bidirectional general-purpose port with shared peripheral pins
// How it works
// - six pins, six direction bits, one each
// - direction one makes input, driver released
// - direction zero drives the output latch
// - data read returns sampled pin levels
// - writes merge pin levels, store in latch
// - bit four: timer clock, open drain
// - analog selection from analog and comparator config
// - power-on: analog pins read as zero
// - comparators start off, yet analog config zero keeps pins analog
// - direction still governs drivers in analog use
// - comparator outputs replace the latch value; slave select releases the driver
// - bit five: slave select, analog, comparator out
// - upper bits six, seven read zero
`timescale 1ns/1ps
module sgp_port (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic por_event,
  input wire logic data_wr,
  input wire logic [sgp_pkg::REG_W-1:0] data_wr_val,
  input wire logic [sgp_pkg::REG_W-1:0] data_wr_mask,
  input wire logic dir_wr,
  input wire logic [sgp_pkg::REG_W-1:0] dir_wr_val,
  input wire logic [3:0] analog_config_reg,
  input wire logic [2:0] comparator_config_reg,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic cmp_out_en,
  input wire logic ss_enable,
  input wire logic [sgp_pkg::PORT_W-1:0] pin_in,
  output logic [sgp_pkg::PORT_W-1:0] pin_out,
  output logic [sgp_pkg::PORT_W-1:0] pin_oe,
  output logic [sgp_pkg::REG_W-1:0] six_bit_port_data,
  output logic [sgp_pkg::REG_W-1:0] pin_direction_reg,
  output logic [sgp_pkg::PORT_W-1:0] analog_sel,
  output logic timer_clock_shared_pin,
  output logic slave_select_shared_pin_n
);
  import sgp_pkg::*;

  logic [PORT_W-1:0] pin_level;
  logic [PORT_W-1:0] latch;
  logic [PORT_W-1:0] dir;
  logic [PORT_W-1:0] next_latch;
  logic [PORT_W-1:0] next_dir;
  logic [PORT_W-1:0] read_val;
  logic [REG_W-1:0] next_data_rd;
  logic [PORT_W-1:0] drive_val;
  logic [PORT_W-1:0] drive_en;
  logic analog_any;
  logic cmp_on;

  sgp_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_async(pin_in),
    .pin_sync(pin_level)
  );

  // Config code zero keeps every capable pin analog; codes 6 and 7 free them unless a comparator is on
  always_comb begin
    cmp_on = (comparator_config_reg != CMP_MODE_OFF);
    analog_any = (analog_config_reg != ACFG_ALL_DIGITAL) && (analog_config_reg[3:1] != 3'h3);
    analog_sel = (analog_any || cmp_on) ? ANALOG_CAPABLE : '0;
  end

  // Analog pins read as zero; this also covers the power-on default
  assign read_val = pin_level & ~analog_sel;

  always_comb begin
    next_latch = latch;
    next_dir = dir;
    if (data_wr) begin
      // Untouched bits take the pin level, so inputs can corrupt the latch
      next_latch = (read_val & ~data_wr_mask[PORT_W-1:0]) |
                   (data_wr_val[PORT_W-1:0] & data_wr_mask[PORT_W-1:0]);
    end
    if (dir_wr) begin
      next_dir = dir_wr_val[PORT_W-1:0];
    end
    next_data_rd = {2'b00, read_val};
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      latch <= LATCH_RESET;
      dir <= DIR_RESET;
      six_bit_port_data <= '0;
    end else begin
      latch <= next_latch;
      dir <= por_event ? DIR_RESET : next_dir;
      six_bit_port_data <= next_data_rd;
    end
  end

  assign pin_direction_reg = {2'b00, dir};

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin
      always_comb begin
        drive_val[gi] = latch[gi];
        drive_en[gi] = ~dir[gi];
        if (gi == TMR_BIT) begin
          drive_val[gi] = cmp_out_en ? cmp1_out : latch[gi];
          // Open drain: only a low is driven
          drive_en[gi] = ~dir[gi] & ~drive_val[gi];
        end else if (gi == SS_BIT) begin
          if (cmp_out_en) begin
            drive_val[gi] = cmp2_out;
          end
          if (ss_enable) begin
            drive_en[gi] = 1'b0;
          end
        end
      end
    end
  endgenerate

  assign pin_out = drive_val;
  assign pin_oe = drive_en;
  assign timer_clock_shared_pin = pin_level[TMR_BIT];
  assign slave_select_shared_pin_n = ss_enable ? pin_level[SS_BIT] : 1'b1;

  a_dir_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
    dir[0] |-> !pin_oe[0]) else $error("input pin is driven");
  a_out_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
    !dir[1] |-> (pin_oe[1] && pin_out[1] == latch[1])) else $error("output misdriven");
  a_od_high: assert property (@(posedge sys_clk) disable iff (!rstn)
    pin_out[TMR_BIT] |-> !pin_oe[TMR_BIT]) else $error("open drain drove high");
  a_read_pins: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 six_bit_port_data[PORT_W-1:0] == $past(read_val)) else $error("read mismatch");
  a_upper_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    six_bit_port_data[7:6] == 2'b00 && pin_direction_reg[7:6] == 2'b00)
    else $error("upper bits nonzero");
  a_rmw_store: assert property (@(posedge sys_clk) disable iff (!rstn)
    data_wr |=> latch == (($past(read_val) & ~$past(data_wr_mask[5:0])) |
    ($past(data_wr_val[5:0]) & $past(data_wr_mask[5:0])))) else $error("rmw wrong");
  a_analog_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    (analog_config_reg == ACFG_RESET) |=> six_bit_port_data[3:0] == 4'h0)
    else $error("analog pin read nonzero");
  a_ss_release: assert property (@(posedge sys_clk) disable iff (!rstn)
    ss_enable |-> !pin_oe[SS_BIT]) else $error("slave select pin driven");
  a_por_dir: assert property (@(posedge sys_clk) disable iff (!rstn)
    por_event |=> dir == DIR_RESET) else $error("direction not reset");
endmodule : sgp_port

/* verilog/sgp_pkg.sv */
// Constants and types for the six-bit general-purpose port
package sgp_pkg;
  localparam int PORT_W = 6;
  localparam int REG_W = 8;
  localparam int TMR_BIT = 4;
  localparam int SS_BIT = 5;
  localparam logic [5:0] DIR_RESET = 6'h3f;
  localparam logic [5:0] LATCH_RESET = 6'h00;
  localparam logic [3:0] ACFG_RESET = 4'h0;
  localparam logic [3:0] ACFG_ALL_DIGITAL = 4'h6;
  localparam logic [2:0] CMP_MODE_OFF = 3'h7;
  localparam logic [5:0] ANALOG_CAPABLE = 6'h2f;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    SGP_WR_IDLE = 2'b00,
    SGP_WR_DATA = 2'b01,
    SGP_WR_DIR = 2'b10
  } sgp_wr_t;
endpackage : sgp_pkg

/* verilog/sgp_pin_sync.sv */
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/1ps
module sgp_pin_sync (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [sgp_pkg::PORT_W-1:0] pin_async,
  output logic [sgp_pkg::PORT_W-1:0] pin_sync
);
  import sgp_pkg::*;
  logic [PORT_W-1:0] stage1;
  logic [PORT_W-1:0] stage2;
  logic [PORT_W-1:0] next_stage1;
  logic [PORT_W-1:0] next_stage2;

  always_comb begin
    next_stage1 = pin_async;
    next_stage2 = stage1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign pin_sync = stage2;
endmodule : sgp_pin_sync

/* bench/sgp_ext_pins.sv */
// Far-side pin circuitry: resolves each pin from device drive and outside source
`timescale 1ns/1ps
module sgp_ext_pins (
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] ext,
  output logic [5:0] level
);
  // Released pins follow the outside source, never a stale value
  assign level = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : sgp_ext_pins

/* bench/tb_sgp_port.sv */
// Self-checking bench for the six-bit port with an integer reference model
`timescale 1ns/1ps
module tb_sgp_port;
  import sgp_pkg::*;
  logic sys_clk = 0, rstn = 0, data_wr = 0, dir_wr = 0, c1 = 0, c2 = 0, tclk, ssn;
  logic [7:0] wval = 0, wmask = 0, dval = 0, rd, dirr;
  logic [3:0] acfg = 0;
  logic [5:0] ext = 6'h3f, lvl, pout, poe, asel;
  logic por = 0, cmpen = 0, ss = 0;
  logic [2:0] ccfg = 3'h7;
  int fail_count = 0, total_checks = 0, cyc = 0, m_dir = 'h3f, m_lat = 0, v, mk, k;
  always #2 sys_clk = ~sys_clk;
  sgp_port uut (.sys_clk(sys_clk), .rstn(rstn), .por_event(por), .data_wr(data_wr),
    .data_wr_val(wval), .data_wr_mask(wmask), .dir_wr(dir_wr), .dir_wr_val(dval),
    .analog_config_reg(acfg), .comparator_config_reg(ccfg), .cmp1_out(c1), .cmp2_out(c2),
    .cmp_out_en(cmpen), .ss_enable(ss), .pin_in(lvl), .pin_out(pout), .pin_oe(poe),
    .six_bit_port_data(rd), .pin_direction_reg(dirr), .analog_sel(asel),
    .timer_clock_shared_pin(tclk), .slave_select_shared_pin_n(ssn));
  sgp_ext_pins far (.pin_out(pout), .pin_oe(poe), .ext(ext), .level(lvl));
  // Bit four only sinks: a latch one leaves the pin to the outside
  function automatic int mlvl();
    return ((ext & m_dir) | (m_lat & ~m_dir & 'h2f) | (~m_dir & m_lat & ext & 'h10)) & 'h3f;
  endfunction : mlvl
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    v = $urandom(32'ha4693148);
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 chk(rd, 8'h10);
    chk(dirr, 8'h3f);
    chk({7'h0, ssn}, 8'h01);
    @(posedge sys_clk);
    acfg <= 4'h6;
    for (int i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      v = $urandom;
      mk = $urandom;
      k = $urandom % 3;
      if (k == 0) begin
        data_wr <= 1'b1;
        m_lat = ((mlvl() & ~mk) | (v & mk)) & 'h3f;
      end else if (k == 1) begin
        dir_wr <= 1'b1;
        m_dir = v & 'h3f;
      end else ext <= 6'(v);
      wval <= 8'(v);
      wmask <= 8'(mk);
      dval <= 8'(v);
      c1 <= v[9];
      c2 <= v[10];
      @(posedge sys_clk);
      data_wr <= 1'b0;
      dir_wr <= 1'b0;
      repeat (5) @(posedge sys_clk);
      #1 chk(rd, 8'(mlvl()));
      chk(dirr, 8'(m_dir));
      chk({2'h0, poe}, 8'(((~m_dir & 'h2f) | (~m_dir & ~m_lat & 'h10)) & 'h3f));
      chk({2'h0, pout & poe & 6'h2f}, 8'(m_lat & ~m_dir & 'h2f));
      chk({7'h0, tclk}, 8'((mlvl() >> 4) & 1));
    end
    // Peripherals take pins over: all outputs, comparator outputs on, slave select releases bit five
    @(posedge sys_clk);
    dir_wr <= 1'b1;
    dval <= 8'h00;
    ss <= 1'b1;
    cmpen <= 1'b1;
    c1 <= 1'b0;
    c2 <= 1'b1;
    ext <= 6'h1f;
    @(posedge sys_clk);
    dir_wr <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 chk({2'h0, poe}, 8'h1f);
    chk({6'h0, pout[5:4]}, 8'h02);
    chk({7'h0, ssn}, 8'h00);
    @(posedge sys_clk);
    ccfg <= 3'h2;
    repeat (5) @(posedge sys_clk);
    #1 chk({2'h0, asel}, 8'h2f);
    chk(rd & 8'h2f, 8'h00);
    @(posedge sys_clk);
    por <= 1'b1;
    @(posedge sys_clk);
    por <= 1'b0;
    @(posedge sys_clk);
    #1 chk(dirr, 8'h3f);
    end_sim();
  end
endmodule : tb_sgp_port
